// ---- core/ucr_regmap.sv ----
`timescale 1ns/1ps
`include "ucr_params.svh"
module ucr_regmap
	import ucr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input ucr_req_t req,
	output logic [7:0] rdata,
	output logic [`UCR_NUM_CH-1:0] tx_load,
	output logic [7:0] tx_data,
	output logic [`UCR_NUM_CH-1:0] rx_pop,
	input wire logic [`UCR_NUM_CH*8-1:0] rx_data,
	input wire logic [`UCR_NUM_CH*8-1:0] int_status_in,
	input wire logic [`UCR_NUM_CH*8-1:0] line_status_in,
	input wire logic [`UCR_NUM_CH*8-1:0] modem_status_in,
	output ucr_cfg_t [`UCR_NUM_CH-1:0] cfg,
	output logic [`UCR_NUM_CH*32-1:0] flow_chars
);
	// ****************************************
	// View decode
	// ****************************************
	function automatic ucr_view_t view_of(input logic [7:0] lctl);
		if (lctl == `UCR_ENH_KEY) begin
			view_of = UCR_VIEW_ENH;
		end else if (lctl[`UCR_LCTL_DIV_BIT]) begin
			view_of = UCR_VIEW_DIV;
		end else begin
			view_of = UCR_VIEW_NORMAL;
		end
	endfunction

	function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m,
		input logic en);
		gate = en ? v : (v & ~m);
	endfunction

	// Write merge: gated bits keep their old value
	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] m, input logic en);
		merge = en ? new_v : ((new_v & ~m) | (old_v & m));
	endfunction

	logic [7:0] tx_data_q;
	logic [`UCR_NUM_CH-1:0] tx_load_d;
	logic [`UCR_NUM_CH-1:0] rx_pop_d;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic [`UCR_NUM_CH*8-1:0] scr_bus;
	ucr_cfg_t sel_cfg;
	ucr_view_t sel_vw;
	logic sel_en;

	assign tx_data = tx_data_q;
	assign tx_load = tx_load_d;
	assign rx_pop = rx_pop_d;
	assign rdata = rdata_q;

	// ****************************************
	// Per-channel register copies
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `UCR_NUM_CH; g++) begin : gen_ch
			logic [7:0] lctl_q;
			logic [7:0] ien_q;
			logic [7:0] fctl_q;
			logic [7:0] mctl_q;
			logic [7:0] efn_q;
			logic [7:0] dlo_q;
			logic [7:0] dhi_q;
			logic [7:0] dfr_q;
			logic [7:0] scr_q;
			logic [7:0] xon1_q;
			logic [7:0] xon2_q;
			logic [7:0] xoff1_q;
			logic [7:0] xoff2_q;
			logic sel_wr;
			logic en;
			ucr_view_t vw;

			assign sel_wr = req.wr && (req.ch == 2'(g));
			assign vw = view_of(lctl_q);
			assign en = efn_q[`UCR_EFN_EN_BIT];

			// Line control, written in every view
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					lctl_q <= `UCR_RST_BYTE;
				end else if (sel_wr && req.ofs == `UCR_OFS_LCTL) begin
					lctl_q <= req.wdata;
				end
			end

			// Enhanced function, reached only through the key value
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					efn_q <= `UCR_RST_BYTE;
				end else if (sel_wr && req.ofs == `UCR_OFS_ISTAT && vw == UCR_VIEW_ENH) begin
					efn_q <= req.wdata;
				end
			end

			// Interrupt enable; gated upper nibble keeps its old value
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ien_q <= `UCR_RST_BYTE;
				end else if (sel_wr && req.ofs == `UCR_OFS_IEN && vw == UCR_VIEW_NORMAL) begin
					ien_q <= merge(ien_q, req.wdata, `UCR_IEN_EXT_MASK, en);
				end
			end

			// FIFO control, write side of offset 2 in the normal view
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					fctl_q <= `UCR_RST_BYTE;
				end else if (sel_wr && req.ofs == `UCR_OFS_ISTAT && vw == UCR_VIEW_NORMAL) begin
					fctl_q <= merge(fctl_q, req.wdata, `UCR_FCTL_EXT_MASK, en);
				end
			end

			// Modem control outside the key view
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mctl_q <= `UCR_RST_BYTE;
				end else if (sel_wr && req.ofs == `UCR_OFS_MCTL && vw != UCR_VIEW_ENH) begin
					mctl_q <= merge(mctl_q, req.wdata, `UCR_MCTL_EXT_MASK, en);
				end
			end

			// Baud divisor bytes; fraction only with the extended bits on
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					dlo_q <= `UCR_RST_BYTE;
					dhi_q <= `UCR_RST_BYTE;
					dfr_q <= `UCR_RST_BYTE;
				end else if (sel_wr && vw == UCR_VIEW_DIV) begin
					case (req.ofs)
						`UCR_OFS_DATA: begin
							dlo_q <= req.wdata;
						end
						`UCR_OFS_IEN: begin
							dhi_q <= req.wdata;
						end
						`UCR_OFS_ISTAT: begin
							if (en) begin
								dfr_q <= req.wdata & `UCR_DFRAC_MASK;
							end
						end
						default: begin
						end
					endcase
				end
			end

			// Scratch pad outside the key view; line and modem status offsets take writes only in the key view
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					scr_q <= `UCR_RST_BYTE;
				end else if (sel_wr && req.ofs == `UCR_OFS_SCR && vw != UCR_VIEW_ENH) begin
					scr_q <= req.wdata;
				end
			end

			// Resume and pause characters behind the key value
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					xon1_q <= `UCR_RST_BYTE;
					xon2_q <= `UCR_RST_BYTE;
					xoff1_q <= `UCR_RST_BYTE;
					xoff2_q <= `UCR_RST_BYTE;
				end else if (sel_wr && vw == UCR_VIEW_ENH) begin
					case (req.ofs)
						`UCR_OFS_MCTL: begin
							xon1_q <= req.wdata;
						end
						`UCR_OFS_LSTAT: begin
							xon2_q <= req.wdata;
						end
						`UCR_OFS_MSTAT: begin
							xoff1_q <= req.wdata;
						end
						`UCR_OFS_SCR: begin
							xoff2_q <= req.wdata;
						end
						default: begin
						end
					endcase
				end
			end

			assign cfg[g].lctl = lctl_q;
			assign cfg[g].ien = gate(ien_q, `UCR_IEN_EXT_MASK, en);
			assign cfg[g].fctl = gate(fctl_q, `UCR_FCTL_EXT_MASK, en);
			assign cfg[g].mctl = gate(mctl_q, `UCR_MCTL_EXT_MASK, en);
			assign cfg[g].efn = efn_q;
			assign cfg[g].div_lo = dlo_q;
			assign cfg[g].div_hi = dhi_q;
			assign cfg[g].div_frac = dfr_q;
			assign flow_chars[g*32 +: 32] = {xoff2_q, xoff1_q, xon2_q, xon1_q};
			assign scr_bus[g*8 +: 8] = scr_q;
		end
	endgenerate

	// ****************************************
	// Read mux and strobes
	// ****************************************
	always_comb begin
		tx_load_d = '0;
		rx_pop_d = '0;
		for (int c = 0; c < `UCR_NUM_CH; c++) begin
			if (req.ch == 2'(c) && req.ofs == `UCR_OFS_DATA &&
				view_of(cfg[c].lctl) == UCR_VIEW_NORMAL) begin
				tx_load_d[c] = req.wr;
				rx_pop_d[c] = req.rd;
			end
		end
	end

	// Selected channel and its view, shared by the read mux
	assign sel_cfg = cfg[req.ch];
	assign sel_vw = view_of(sel_cfg.lctl);
	assign sel_en = sel_cfg.efn[`UCR_EFN_EN_BIT];

	always_comb begin
		rdata_d = 8'h00;
		case (req.ofs)
			`UCR_OFS_DATA: begin
				if (sel_vw == UCR_VIEW_NORMAL) begin
					rdata_d = rx_data[req.ch*8 +: 8];
				end else begin
					rdata_d = sel_cfg.div_lo;
				end
			end
			`UCR_OFS_IEN: begin
				if (sel_vw == UCR_VIEW_DIV) begin
					rdata_d = sel_cfg.div_hi;
				end else begin
					rdata_d = sel_cfg.ien;
				end
			end
			`UCR_OFS_ISTAT: begin
				case (sel_vw)
					UCR_VIEW_ENH: rdata_d = sel_cfg.efn;
					UCR_VIEW_DIV: rdata_d = sel_en ? sel_cfg.div_frac : 8'h00;
					default: rdata_d = gate(int_status_in[req.ch*8 +: 8], `UCR_ISTAT_EXT_MASK,
						sel_en);
				endcase
			end
			`UCR_OFS_LCTL: begin
				rdata_d = sel_cfg.lctl;
			end
			`UCR_OFS_MCTL: begin
				if (sel_vw == UCR_VIEW_ENH) begin
					rdata_d = flow_chars[req.ch*32 +: 8];
				end else begin
					rdata_d = sel_cfg.mctl;
				end
			end
			`UCR_OFS_LSTAT: begin
				if (sel_vw == UCR_VIEW_ENH) begin
					rdata_d = flow_chars[req.ch*32+8 +: 8];
				end else begin
					rdata_d = line_status_in[req.ch*8 +: 8];
				end
			end
			`UCR_OFS_MSTAT: begin
				if (sel_vw == UCR_VIEW_ENH) begin
					rdata_d = flow_chars[req.ch*32+16 +: 8];
				end else begin
					rdata_d = modem_status_in[req.ch*8 +: 8];
				end
			end
			default: begin
				if (sel_vw == UCR_VIEW_ENH) begin
					rdata_d = flow_chars[req.ch*32+24 +: 8];
				end else begin
					rdata_d = scr_bus[req.ch*8 +: 8];
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_data_q <= 8'h00;
		end else if (|tx_load_d) begin
			tx_data_q <= req.wdata;
		end
	end
endmodule

// ---- shared/ucr_params.svh ----
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH
`define UCR_NUM_CH 4
`define UCR_OFS_DATA 3'h0
`define UCR_OFS_IEN 3'h1
`define UCR_OFS_ISTAT 3'h2
`define UCR_OFS_LCTL 3'h3
`define UCR_OFS_MCTL 3'h4
`define UCR_OFS_LSTAT 3'h5
`define UCR_OFS_MSTAT 3'h6
`define UCR_OFS_SCR 3'h7
`define UCR_ENH_KEY 8'hBF
`define UCR_LCTL_DIV_BIT 7
`define UCR_EFN_EN_BIT 4
`define UCR_IEN_EXT_MASK 8'hF0
`define UCR_ISTAT_EXT_MASK 8'h30
`define UCR_FCTL_EXT_MASK 8'h30
`define UCR_MCTL_EXT_MASK 8'hE0
`define UCR_DFRAC_MASK 8'h3F
`define UCR_RST_BYTE 8'h00
`define UCR_LSTAT_RST 8'h60
`endif

// ---- shared/ucr_pkg.sv ----
package ucr_pkg;
	typedef struct packed {
		logic [1:0] ch;
		logic [2:0] ofs;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ucr_req_t;
	typedef struct packed {
		logic [7:0] lctl;
		logic [7:0] ien;
		logic [7:0] fctl;
		logic [7:0] mctl;
		logic [7:0] efn;
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] div_frac;
	} ucr_cfg_t;
	typedef enum logic [1:0] {
		UCR_VIEW_NORMAL = 2'b00,
		UCR_VIEW_DIV = 2'b01,
		UCR_VIEW_ENH = 2'b11
	} ucr_view_t;
endpackage

// ---- bench/ucr_regmap_asserts.sv ----
`timescale 1ns/1ps
`include "ucr_params.svh"
// ****************
// Port relation checks
// ****************
module ucr_regmap_asserts
	import ucr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input ucr_req_t req,
	input wire logic [7:0] rdata,
	input wire logic [`UCR_NUM_CH-1:0] tx_load,
	input wire logic [7:0] tx_data,
	input wire logic [`UCR_NUM_CH-1:0] rx_pop,
	input wire logic [`UCR_NUM_CH*8-1:0] rx_data,
	input wire logic [`UCR_NUM_CH*8-1:0] int_status_in,
	input wire logic [`UCR_NUM_CH*8-1:0] line_status_in,
	input wire logic [`UCR_NUM_CH*8-1:0] modem_status_in,
	input ucr_cfg_t [`UCR_NUM_CH-1:0] cfg,
	input wire logic [`UCR_NUM_CH*32-1:0] flow_chars
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_tx;
		req.wr && req.ofs == 3'h0 && !cfg[req.ch].lctl[7] |-> tx_load == 4'h1 << req.ch;
	endproperty
	a_tx: assert property (p_tx) else $error("tx load wrong");
	property p_pop;
		req.rd && req.ofs == 3'h0 && !cfg[req.ch].lctl[7] |-> rx_pop == 4'h1 << req.ch;
	endproperty
	a_pop: assert property (p_pop) else $error("rx pop wrong");
	property p_idle;
		!req.wr && !req.rd |-> tx_load == 4'h0 && rx_pop == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe without request");
	property p_txd;
		tx_load != 4'h0 |=> tx_data == $past(req.wdata);
	endproperty
	a_txd: assert property (p_txd) else $error("tx data wrong");
	property p_lsr;
		req.rd && req.ofs == 3'h5 && !cfg[req.ch].lctl[7]
			|=> rdata == 8'($past(line_status_in) >> {$past(req.ch), 3'h0});
	endproperty
	a_lsr: assert property (p_lsr) else $error("line status read wrong");
	property p_lcr;
		req.wr && req.ofs == 3'h3 |=> cfg[$past(req.ch)].lctl == $past(req.wdata);
	endproperty
	a_lcr: assert property (p_lcr) else $error("line control wrong");
	property p_efn;
		req.wr && req.ofs == 3'h2 && cfg[req.ch].lctl == 8'hBF
			|=> cfg[$past(req.ch)].efn == $past(req.wdata);
	endproperty
	a_efn: assert property (p_efn) else $error("enhanced write lost");
	property p_iso;
		req.wr && req.ch != 2'h0 |=> $stable(cfg[0]);
	endproperty
	a_iso: assert property (p_iso) else $error("channel 0 disturbed");
	property p_gate;
		!cfg[0].efn[4] |-> cfg[0].ien[7:4] == 4'h0 && cfg[0].mctl[7:5] == 3'h0 &&
			cfg[0].fctl[5:4] == 2'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("gated bits set");
	property p_flow;
		req.wr && req.ofs == 3'h4 && cfg[req.ch].lctl == 8'hBF
			|=> flow_chars[{$past(req.ch), 5'h00}+:8] == $past(req.wdata);
	endproperty
	a_flow: assert property (p_flow) else $error("resume char wrong");
endmodule

// ---- bench/ucr_host.sv ----
`timescale 1ns/1ps
// ****************
// Host bus model
// ****************
module ucr_host
	import ucr_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	output ucr_req_t req
);
	initial begin
		req = '0;
	end
	// Idle data inverted so stale bytes never look valid
	task automatic wr(input logic [1:0] c, input logic [2:0] o, input logic [7:0] d);
		@(negedge clk);
		req = {c, o, d, 2'b10};
		@(negedge clk);
		req = {c, o, ~d, 2'b00};
	endtask
	task automatic rd(input logic [1:0] c, input logic [2:0] o, output logic [7:0] d);
		@(negedge clk);
		req = {c, o, 8'h00, 2'b01};
		@(negedge clk);
		req = {c, o, 8'hFF, 2'b00};
		d = rdata;
	endtask
endmodule

// ---- bench/uart_channel_register_map_bench.sv ----
`timescale 1ns/1ps
// ****************
// Register map bench
// ****************
module uart_channel_register_map_bench import ucr_pkg::*;;
	logic clk, rst_n;
	ucr_req_t req;
	logic [7:0] rdata, tx_data, d;
	logic [3:0] tx_load, rx_pop;
	logic [31:0] rx_data, ist, lst, mst;
	ucr_cfg_t [3:0] cfg;
	logic [127:0] flow_chars;
	int n_mismatch, num_checks, cyc;
	ucr_regmap dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .tx_load(tx_load),
		.tx_data(tx_data), .rx_pop(rx_pop), .rx_data(rx_data), .int_status_in(ist),
		.line_status_in(lst), .modem_status_in(mst), .cfg(cfg), .flow_chars(flow_chars));
	ucr_host h_u (.clk(clk), .rdata(rdata), .req(req));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic t_div();
		h_u.wr(2'h1, 3'h3, 8'h80);
		h_u.wr(2'h1, 3'h0, 8'h12);
		h_u.wr(2'h1, 3'h1, 8'h34);
		chk({cfg[1].div_hi, cfg[1].div_lo, cfg[1].ien}, 32'h341200);
		h_u.wr(2'h1, 3'h2, 8'hFF);
		h_u.rd(2'h1, 3'h2, d);
		chk(d, 8'h00);
		h_u.wr(2'h1, 3'h3, 8'hBF);
		h_u.wr(2'h1, 3'h2, 8'h10);
		chk(cfg[1].efn, 8'h10);
		for (int i = 4; i < 8; i++) h_u.wr(2'h1, 3'(i), 8'(i * 17));
		chk(flow_chars[63:32], 32'h77665544);
		h_u.wr(2'h1, 3'h3, 8'h80);
		h_u.wr(2'h1, 3'h2, 8'hFF);
		h_u.rd(2'h1, 3'h2, d);
		chk(d, 8'h3F);
	endtask
	task automatic t_gate();
		h_u.wr(2'h0, 3'h1, 8'hFF);
		h_u.rd(2'h0, 3'h1, d);
		chk(d, 8'h0F);
		h_u.rd(2'h0, 3'h2, d);
		chk(d, 8'hCF);
		h_u.wr(2'h0, 3'h2, 8'h3F);
		h_u.wr(2'h0, 3'h4, 8'hFF);
		chk({cfg[0].fctl, cfg[0].mctl}, 16'h0F1F);
		h_u.wr(2'h0, 3'h3, 8'hBF);
		h_u.wr(2'h0, 3'h2, 8'h10);
		h_u.wr(2'h0, 3'h3, 8'h03);
		h_u.wr(2'h0, 3'h1, 8'hFF);
		h_u.rd(2'h0, 3'h1, d);
		chk(d, 8'hFF);
		h_u.rd(2'h0, 3'h2, d);
		chk(d, 8'hFF);
		chk(cfg[0].lctl, 8'h03);
		h_u.wr(2'h0, 3'h2, 8'h3F);
		h_u.wr(2'h0, 3'h4, 8'hFF);
		chk({cfg[0].fctl, cfg[0].mctl}, 16'h3FFF);
	endtask
	task automatic t_rst();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk(flow_chars[63:32], 32'h0);
		chk(cfg[0].lctl, 8'h00);
		h_u.wr(2'h3, 3'h7, 8'h5A);
		h_u.rd(2'h3, 3'h7, d);
		chk(d, 8'h5A);
	endtask
	task automatic t_data();
		h_u.wr(2'h2, 3'h0, 8'hA5);
		chk(tx_data, 8'hA5);
		h_u.rd(2'h2, 3'h0, d);
		chk(d, 8'h22);
		h_u.rd(2'h2, 3'h5, d);
		chk(d, 8'hE1);
		h_u.rd(2'h2, 3'h6, d);
		chk(d, 8'hB0);
		h_u.wr(2'h2, 3'h7, 8'h77);
		h_u.rd(2'h2, 3'h7, d);
		chk(d, 8'h77);
	endtask
	initial begin
		rst_n = 1'b0;
		rx_data = 32'h11223344;
		ist = 32'hFFFFFFFF;
		lst = 32'h00E10000;
		mst = 32'h00B00000;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk(flow_chars[31:0], 32'h0);
		t_div();
		t_gate();
		t_data();
		t_rst();
		stop_test();
	end
endmodule
bind ucr_regmap ucr_regmap_asserts chk_u (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
	.tx_load(tx_load), .tx_data(tx_data), .rx_pop(rx_pop), .rx_data(rx_data),
	.int_status_in(int_status_in), .line_status_in(line_status_in),
	.modem_status_in(modem_status_in), .cfg(cfg), .flow_chars(flow_chars));
